// ==== rtl/acr_defines.svh ====
// Purpose: Offsets, field positions, reset values, write masks and sequence seeds of the converter control registers.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes: Definitions only.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_OFS_CHAN_SEL 8'h05
`define ACR_OFS_POWER 8'h08
`define ACR_OFS_CLOCK 8'h09
`define ACR_OFS_CLK_DIV 8'h0B
`define ACR_OFS_PATTERN 8'h0D
`define ACR_OFS_SELF_CHECK 8'h0E
`define ACR_OFS_COMMIT 8'hFF
`define ACR_RST_CHAN_SEL 8'hFF
`define ACR_RST_POWER 8'h80
`define ACR_RST_ZERO 8'h00
`define ACR_MASK_CHAN_SEL 8'h03
`define ACR_MASK_POWER 8'hE3
`define ACR_MASK_CLOCK 8'h01
`define ACR_MASK_CLK_DIV 8'h07
`define ACR_MASK_PATTERN 8'hFF
`define ACR_MASK_SELF_CHECK 8'h05
`define ACR_BIT_COMMIT 0
`define ACR_BIT_PD_ENABLE 7
`define ACR_POS_PD_FUNC 5
`define ACR_POS_PWR 0
`define ACR_BIT_STABILIZER 0
`define ACR_POS_DIV 0
`define ACR_POS_USER_MODE 6
`define ACR_BIT_RESET_LONG 5
`define ACR_BIT_RESET_SHORT 4
`define ACR_POS_TEST 0
`define ACR_BIT_SELF_START 0
`define ACR_BIT_SELF_INIT 2
`define ACR_LONG_SEED 23'h7FFFFF
`define ACR_SHORT_SEED 9'h1FF
`endif

// ==== rtl/acr_pkg.sv ====
// Purpose: Types shared by the converter control register bank.
// Assumes: Defines header is compiled alongside.
// Notes: Holds no numbers of its own beyond encodings.
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_PWR_RUN = 2'h0,
        ACR_PWR_OFF = 2'h1,
        ACR_PWR_STANDBY = 2'h2,
        ACR_PWR_DIG_RESET = 2'h3
    } acr_power_e;
    typedef enum logic [3:0] {
        ACR_TEST_OFF = 4'h0,
        ACR_TEST_MIDSCALE = 4'h1,
        ACR_TEST_POS_FULL = 4'h2,
        ACR_TEST_NEG_FULL = 4'h3,
        ACR_TEST_CHECKER = 4'h4,
        ACR_TEST_LONG_PRS = 4'h5,
        ACR_TEST_SHORT_PRS = 4'h6,
        ACR_TEST_WORD_TOGGLE = 4'h7,
        ACR_TEST_USER = 4'h8,
        ACR_TEST_BIT_TOGGLE = 4'h9
    } acr_test_e;
    typedef struct packed {
        logic [7:0] power;
        logic [7:0] pattern;
    } acr_chan_s;
    typedef struct packed {
        logic [7:0] clock;
        logic [7:0] clk_div;
        logic [7:0] self_check;
    } acr_global_s;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acr_req_s;
endpackage : acr_pkg

// ==== rtl/acr_test_gen.sv ====
// Purpose: Per-channel output test data generator with two pseudo-random sequences.
// Assumes: Runs every clock; selector and controls come from active registers.
// Notes: Output registered.
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"
module acr_test_gen #(
    parameter int DW = 14
) (
    input wire logic mclk, // Clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [3:0] sel, // Active test selector.
    input wire logic rst_long, // Hold long sequence at its seed.
    input wire logic rst_short, // Hold short sequence at its seed.
    input wire logic [DW-1:0] sample, // Converted sample.
    output logic [DW-1:0] dout // Output data word.
);
    typedef struct packed {
        logic [22:0] lfsr_long;
        logic [8:0] lfsr_short;
        logic phase;
        logic [DW-1:0] dout;
    } acr_tg_s;
    acr_tg_s st;
    acr_tg_s next_st;
    function automatic logic [DW-1:0] fill(input logic b);
        fill = {DW{b}};
    endfunction : fill
    always_comb begin
        next_st = st;
        next_st.phase = ~st.phase;
        // Long sequence x^23 + x^18 + 1, short x^9 + x^5 + 1.
        next_st.lfsr_long = rst_long ? `ACR_LONG_SEED
            : {st.lfsr_long[21:0], st.lfsr_long[22] ^ st.lfsr_long[17]};
        next_st.lfsr_short = rst_short ? `ACR_SHORT_SEED
            : {st.lfsr_short[7:0], st.lfsr_short[8] ^ st.lfsr_short[4]};
        case (acr_pkg::acr_test_e'(sel))
            acr_pkg::ACR_TEST_OFF: next_st.dout = sample;
            acr_pkg::ACR_TEST_MIDSCALE: next_st.dout = {1'b1, {(DW-1){1'b0}}};
            acr_pkg::ACR_TEST_POS_FULL: next_st.dout = fill(1'b1);
            acr_pkg::ACR_TEST_NEG_FULL: next_st.dout = fill(1'b0);
            acr_pkg::ACR_TEST_CHECKER: next_st.dout = st.phase ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
            acr_pkg::ACR_TEST_LONG_PRS: next_st.dout = st.lfsr_long[DW-1:0];
            acr_pkg::ACR_TEST_SHORT_PRS: next_st.dout = {{(DW-9){1'b0}}, st.lfsr_short};
            acr_pkg::ACR_TEST_WORD_TOGGLE: next_st.dout = fill(st.phase);
            acr_pkg::ACR_TEST_USER: next_st.dout = fill(1'b0);
            acr_pkg::ACR_TEST_BIT_TOGGLE: next_st.dout = {{(DW-1){1'b0}}, st.phase};
            default: next_st.dout = sample;
        endcase
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{lfsr_long: `ACR_LONG_SEED, lfsr_short: `ACR_SHORT_SEED,
                    phase: 1'b0, dout: '0};
        end else begin
            st <= next_st;
        end
    end
    assign dout = st.dout;
    property p_long_reset;
        @(posedge mclk) disable iff (!resetn) rst_long |=> st.lfsr_long == `ACR_LONG_SEED;
    endproperty
    a_long_reset: assert property (p_long_reset) else $error("long sequence not reseeded");
    property p_off_passes;
        @(posedge mclk) disable iff (!resetn) sel == 4'h0 |=> dout == $past(sample);
    endproperty
    a_off_passes: assert property (p_off_passes) else $error("sample not passed when off");
endmodule : acr_test_gen
`default_nettype wire

// ==== rtl/acr_regs.sv ====
// Purpose: Control register bank of a dual-channel converter with shadowed settings.
// Assumes: Register port is a byte-wide synchronous request from serial port logic.
// Notes: Serial framing lives outside this block.
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"
module acr_regs #(
    parameter int DW = 14,
    parameter int NCH = 2
) (
    input wire logic mclk, // Clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire acr_pkg::acr_req_s req, // Register request from serial port.
    output logic [7:0] rdata, // Read data, valid the cycle after rd.
    input wire logic pd_pin, // External power-down pin, asynchronous.
    input wire logic [NCH*DW-1:0] sample, // Converted samples per channel.
    output logic [NCH*DW-1:0] data_out, // Output data lines per channel.
    output logic [NCH*2-1:0] power_state, // Effective power state per channel.
    output logic [NCH-1:0] user_mode_once, // User pattern plays once.
    output logic [NCH-1:0] user_mode_alt, // User pattern alternates.
    output logic chip_reset, // Chip-wide digital reset request.
    output logic stabilizer_en, // Duty-cycle stabilizer enable.
    output logic [2:0] clk_div, // Input clock divide value minus one.
    output logic self_check_start, // Built-in self-check start level.
    output logic self_check_init // Self-check initialise level.
);
    typedef struct packed {
        logic [7:0] chan_sel;
        acr_pkg::acr_chan_s [NCH-1:0] hold_ch;
        acr_pkg::acr_chan_s [NCH-1:0] act_ch;
        acr_pkg::acr_global_s hold_g;
        acr_pkg::acr_global_s act_g;
        logic commit;
        logic [1:0] pd_sync;
        logic [7:0] rdata;
        logic [NCH*2-1:0] power_state;
        logic [NCH-1:0] user_once;
        logic [NCH-1:0] user_alt;
        logic chip_reset;
    } acr_st_s;
    acr_st_s st;
    acr_st_s next_st;
    localparam acr_pkg::acr_chan_s CH_RST = '{power: `ACR_RST_POWER, pattern: `ACR_RST_ZERO};
    localparam acr_pkg::acr_global_s G_RST = '{clock: `ACR_RST_ZERO, clk_div: `ACR_RST_ZERO,
                                               self_check: `ACR_RST_ZERO};
    // Lowest selected channel wins a read so that dual selection returns channel A.
    function automatic int first_sel(input logic [7:0] s);
        first_sel = 0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (s[i]) begin
                first_sel = i;
            end
        end
    endfunction : first_sel
    function automatic logic [1:0] eff_power(input logic [7:0] pw, input logic pin);
        eff_power = pw[`ACR_POS_PWR +: 2];
        if (pin && pw[`ACR_BIT_PD_ENABLE]) begin
            eff_power = pw[`ACR_POS_PD_FUNC] ? acr_pkg::ACR_PWR_STANDBY : acr_pkg::ACR_PWR_OFF;
        end
    endfunction : eff_power
    always_comb begin
        int rc;
        rc = first_sel(st.chan_sel);
        next_st = st;
        next_st.pd_sync = {st.pd_sync[0], pd_pin};
        next_st.commit = 1'b0;
        if (st.commit) begin
            next_st.act_ch = st.hold_ch;
            next_st.act_g = st.hold_g;
        end
        if (req.wr) begin
            case (req.addr)
                `ACR_OFS_CHAN_SEL: next_st.chan_sel = req.wdata & `ACR_MASK_CHAN_SEL;
                `ACR_OFS_CLOCK: next_st.hold_g.clock = req.wdata & `ACR_MASK_CLOCK;
                `ACR_OFS_CLK_DIV: next_st.hold_g.clk_div = req.wdata & `ACR_MASK_CLK_DIV;
                `ACR_OFS_SELF_CHECK: next_st.hold_g.self_check = req.wdata & `ACR_MASK_SELF_CHECK;
                `ACR_OFS_COMMIT: next_st.commit = req.wdata[`ACR_BIT_COMMIT];
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (st.chan_sel[i]) begin
                    if (req.addr == `ACR_OFS_POWER) begin
                        next_st.hold_ch[i].power = req.wdata & `ACR_MASK_POWER;
                    end
                    if (req.addr == `ACR_OFS_PATTERN) begin
                        next_st.hold_ch[i].pattern = req.wdata & `ACR_MASK_PATTERN;
                    end
                end
            end
        end
        next_st.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `ACR_OFS_CHAN_SEL: next_st.rdata = st.chan_sel;
                `ACR_OFS_POWER: next_st.rdata = st.hold_ch[rc].power;
                `ACR_OFS_CLOCK: next_st.rdata = st.hold_g.clock;
                `ACR_OFS_CLK_DIV: next_st.rdata = st.hold_g.clk_div;
                `ACR_OFS_PATTERN: next_st.rdata = st.hold_ch[rc].pattern;
                `ACR_OFS_SELF_CHECK: next_st.rdata = st.hold_g.self_check;
                `ACR_OFS_COMMIT: next_st.rdata = {7'h00, st.commit};
                default: next_st.rdata = 8'h00;
            endcase
        end
        next_st.chip_reset = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            next_st.power_state[2*i +: 2] = eff_power(st.act_ch[i].power, st.pd_sync[1]);
            if (st.act_ch[i].power[`ACR_POS_PWR +: 2] == acr_pkg::ACR_PWR_DIG_RESET) begin
                next_st.chip_reset = 1'b1;
            end
            next_st.user_once[i] = st.act_ch[i].pattern[`ACR_POS_USER_MODE + 1];
            next_st.user_alt[i] = st.act_ch[i].pattern[`ACR_POS_USER_MODE];
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '{chan_sel: `ACR_RST_CHAN_SEL, hold_ch: {NCH{CH_RST}}, act_ch: {NCH{CH_RST}},
                    hold_g: G_RST, act_g: G_RST, commit: 1'b0, pd_sync: 2'h0, rdata: 8'h00,
                    power_state: '0, user_once: '0, user_alt: '0, chip_reset: 1'b0};
        end else begin
            st <= next_st;
        end
    end
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            acr_test_gen #(.DW(DW)) u_gen (
                .mclk(mclk),
                .resetn(resetn),
                .sel(st.act_ch[g].pattern[`ACR_POS_TEST +: 4]),
                .rst_long(st.act_ch[g].pattern[`ACR_BIT_RESET_LONG]),
                .rst_short(st.act_ch[g].pattern[`ACR_BIT_RESET_SHORT]),
                .sample(sample[g*DW +: DW]),
                .dout(data_out[g*DW +: DW])
            );
        end
    endgenerate
    assign rdata = st.rdata;
    assign power_state = st.power_state;
    assign user_mode_once = st.user_once;
    assign user_mode_alt = st.user_alt;
    assign chip_reset = st.chip_reset;
    assign stabilizer_en = st.act_g.clock[`ACR_BIT_STABILIZER];
    assign clk_div = st.act_g.clk_div[`ACR_POS_DIV +: 3];
    assign self_check_start = st.act_g.self_check[`ACR_BIT_SELF_START];
    assign self_check_init = st.act_g.self_check[`ACR_BIT_SELF_INIT];
    property p_commit_clears;
        @(posedge mclk) disable iff (!resetn) st.commit |=> !st.commit || $past(req.wr);
    endproperty
    a_commit_clears: assert property (p_commit_clears) else $error("commit bit stuck");
    property p_hold_no_effect;
        @(posedge mclk) disable iff (!resetn)
            !st.commit |=> st.act_g == $past(st.act_g) && st.act_ch == $past(st.act_ch);
    endproperty
    a_hold_no_effect: assert property (p_hold_no_effect) else $error("active changed");
    property p_commit_copies;
        @(posedge mclk) disable iff (!resetn)
            st.commit |=> st.act_g == $past(st.hold_g) && st.act_ch == $past(st.hold_ch);
    endproperty
    a_commit_copies: assert property (p_commit_copies) else $error("commit copy wrong");
    property p_sel_write;
        @(posedge mclk) disable iff (!resetn)
            req.wr && req.addr == `ACR_OFS_POWER && st.chan_sel[1] && !st.chan_sel[0]
            |=> st.hold_ch[0].power == $past(st.hold_ch[0].power);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("unselected channel written");
    property p_read_a;
        @(posedge mclk) disable iff (!resetn)
            req.rd && req.addr == `ACR_OFS_PATTERN && st.chan_sel[0]
            |=> rdata == $past(st.hold_ch[0].pattern);
    endproperty
    a_read_a: assert property (p_read_a) else $error("read did not return channel A");
    property p_dig_reset;
        @(posedge mclk) disable iff (!resetn)
            st.act_ch[0].power[1:0] == 2'h3 |=> chip_reset;
    endproperty
    a_dig_reset: assert property (p_dig_reset) else $error("digital reset missing");
    property p_pin_pd;
        @(posedge mclk) disable iff (!resetn)
            st.pd_sync[1] && st.act_ch[0].power[7] && !st.act_ch[0].power[5]
            |=> power_state[1:0] == 2'h1;
    endproperty
    a_pin_pd: assert property (p_pin_pd) else $error("pin power-down ignored");
    property p_stab;
        @(posedge mclk) disable iff (!resetn) stabilizer_en == st.act_g.clock[0] ##0
            (st.commit ##1 stabilizer_en == $past(st.hold_g.clock[0])) or !st.commit;
    endproperty
    a_stab: assert property (p_stab) else $error("stabilizer not applied");
    c_commit: cover property (@(posedge mclk) disable iff (!resetn) st.commit);
    c_both_write: cover property (@(posedge mclk) disable iff (!resetn)
        req.wr && req.addr == `ACR_OFS_PATTERN && st.chan_sel[1:0] == 2'h3);
    c_pin: cover property (@(posedge mclk) disable iff (!resetn) st.pd_sync[1]);
endmodule : acr_regs
`default_nettype wire

// ==== verification/acr_host_model.sv ====
// Purpose: Serial control port host that issues byte register requests to the bank.
// Assumes: One request per call, launched and released at rising clock edges.
// Notes: A released address and data bus shows the inverse of the last value, not a hold.
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
    input wire logic mclk, // Clock.
    output var acr_pkg::acr_req_s req, // Request to the register bank.
    input wire logic [7:0] rdata // Read data from the register bank.
);
    initial req = '0;

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : write_reg

    // Shadowed settings only act once the host issues this write.
    task automatic commit();
        write_reg(8'hFF, 8'h01);
    endtask : commit

    // The caller may leave both channels selected before a local read; the bank then returns channel A.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        #1;
        d = rdata;
    endtask : read_reg
endmodule : acr_host_model
`default_nettype wire

// ==== verification/acr_regs_tb.sv ====
// Purpose: Self-checking bench for the converter control register bank.
// Assumes: Register latencies as handed over; six idle cycles cover commit to output.
// Notes: Test pattern values are format dependent, so codes are checked against the sample.
`timescale 1ns/10ps
`default_nettype none
module acr_regs_tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic pd_pin = 1'b0;
    logic [27:0] sample = 28'h48D0ABC;
    acr_pkg::acr_req_s req;
    logic [7:0] rdata;
    logic [27:0] data_out;
    logic [3:0] power_state;
    logic [1:0] once;
    logic [1:0] alt;
    logic chip_reset, stab, sc_start, sc_init;
    logic [2:0] div;
    logic [27:0] prev;
    logic [7:0] rst_addr [8] = '{8'h05, 8'h08, 8'h09, 8'h0B, 8'h0D, 8'h0E, 8'hFF, 8'h13};
    logic [7:0] rst_val [8] = '{8'hFF, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int bad_count = 0;
    int cmp_count = 0;

    acr_regs #(.DW(14), .NCH(2)) dut (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
        .pd_pin(pd_pin), .sample(sample), .data_out(data_out), .power_state(power_state),
        .user_mode_once(once), .user_mode_alt(alt), .chip_reset(chip_reset),
        .stabilizer_en(stab), .clk_div(div), .self_check_start(sc_start),
        .self_check_init(sc_init));
    acr_host_model host (.mclk(mclk), .req(req), .rdata(rdata));

    always #50 mclk = ~mclk;

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        chk(name, {24'h0, d}, {24'h0, e});
    endtask : rd_chk

    // Commit the holding registers and let the active values reach the outputs.
    task automatic apply();
        host.commit();
        wt(6);
    endtask : apply

    initial begin
        repeat (20000) @(posedge mclk);
        $display("Error watchdog expected finish seen hang");
        bad_count++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        wt(2);
        for (int i = 0; i < 8; i++) rd_chk("reset value", rst_addr[i], rst_val[i]);
        chk("reset power", {28'h0, power_state}, 32'h0);
        chk("reset stabilizer", {31'h0, stab}, 32'h0);
        chk("reset data", {4'h0, data_out}, {4'h0, sample});
        $display("Test reset values done");

        host.write_reg(8'h0B, 8'h07);
        host.write_reg(8'h09, 8'h01);
        host.write_reg(8'h0E, 8'h05);
        wt(4);
        chk("divider before commit", {29'h0, div}, 32'h0);
        chk("stabilizer before commit", {31'h0, stab}, 32'h0);
        apply();
        chk("divider", {29'h0, div}, 32'h7);
        chk("stabilizer", {31'h0, stab}, 32'h1);
        chk("self check start", {31'h0, sc_start}, 32'h1);
        chk("self check init", {31'h0, sc_init}, 32'h1);
        rd_chk("commit cleared", 8'hFF, 8'h00);
        host.write_reg(8'h0B, 8'h00);
        host.write_reg(8'h09, 8'h00);
        apply();
        chk("divider by one", {29'h0, div}, 32'h0);
        chk("stabilizer off", {31'h0, stab}, 32'h0);
        $display("Test commit done");

        host.write_reg(8'h05, 8'h01);
        for (int c = 0; c < 4; c++) begin
            host.write_reg(8'h08, 8'(c));
            apply();
            chk("power code", {30'h0, power_state[1:0]}, 32'(c));
            chk("other channel", {30'h0, power_state[3:2]}, 32'h0);
            chk("chip reset", {31'h0, chip_reset}, {31'h0, c == 3});
        end
        host.write_reg(8'h08, 8'h00);
        apply();
        $display("Test power codes done");

        host.write_reg(8'h05, 8'h03);
        host.write_reg(8'h08, 8'h80);
        apply();
        @(posedge mclk) pd_pin <= 1'b1;
        wt(6);
        chk("pin power down", {28'h0, power_state}, 32'h5);
        host.write_reg(8'h08, 8'hA0);
        apply();
        chk("pin standby", {28'h0, power_state}, 32'hA);
        host.write_reg(8'h08, 8'h00);
        apply();
        chk("pin disabled", {28'h0, power_state}, 32'h0);
        @(posedge mclk) pd_pin <= 1'b0;
        $display("Test power pin done");

        for (int m = 0; m < 4; m++) begin
            host.write_reg(8'h05, 8'h03);
            host.write_reg(8'h0D, 8'h40);
            host.write_reg(8'h05, 8'h02);
            host.write_reg(8'h0D, 8'(m << 6));
            apply();
            chk("mode once", {30'h0, once}, {30'h0, m[1], 1'b0});
            chk("mode alternate", {30'h0, alt}, {30'h0, m[0], 1'b1});
            host.write_reg(8'h05, 8'h03);
            rd_chk("both selected read", 8'h0D, 8'h40);
        end
        host.write_reg(8'h0D, 8'h00);
        apply();
        $display("Test user modes done");

        host.write_reg(8'h05, 8'h01);
        for (int t = 1; t < 10; t++) begin
            host.write_reg(8'h0D, 8'(t));
            apply();
            chk("test replaces sample", {31'h0, data_out[13:0] !== sample[13:0]}, 32'h1);
            chk("unselected channel", {18'h0, data_out[27:14]}, {18'h0, sample[27:14]});
        end
        for (int g = 0; g < 2; g++) begin
            host.write_reg(8'h0D, g ? 8'h16 : 8'h25);
            apply();
            prev = data_out;
            wt(1);
            chk("generator held", {4'h0, data_out}, {4'h0, prev});
            host.write_reg(8'h0D, g ? 8'h06 : 8'h05);
            apply();
            prev = data_out;
            wt(1);
            chk("generator runs", {31'h0, data_out[13:0] !== prev[13:0]}, 32'h1);
        end
        host.write_reg(8'h0D, 8'h00);
        apply();
        chk("test off", {4'h0, data_out}, {4'h0, sample});
        $display("Test patterns done");
        test_done();
    end
endmodule : acr_regs_tb
`default_nettype wire
